// *** shared/cfl_pkg.sv ***
// Purpose: shared constants for the status flag and arithmetic datapath block
// Assumes: 8-bit core, phi derived from mclk by the main clock division ratio field
// Notes:   offsets are byte addresses on the plain register port
package cfl_pkg;
	// ****************************************************************
	// flag positions and reset value
	// ****************************************************************
	localparam int unsigned FLAG_C = 0;
	localparam int unsigned FLAG_Z = 1;
	localparam int unsigned FLAG_I = 2;
	localparam int unsigned FLAG_D = 3;
	localparam int unsigned FLAG_B = 4;
	localparam int unsigned FLAG_T = 5;
	localparam int unsigned FLAG_V = 6;
	localparam int unsigned FLAG_N = 7;
	localparam logic [7:0] PS_RESET = 8'h04; // only interrupt disable defined

	// ****************************************************************
	// register map
	// ****************************************************************
	localparam logic [7:0] ADDR_DIR0     = 8'h01; // port direction, write-only
	localparam logic [7:0] ADDR_DIR1     = 8'h03; // port direction, write-only
	localparam logic [7:0] ADDR_CLKMODE  = 8'h3B; // main clock division ratio at bits 7:6
	localparam logic [7:0] ADDR_IRQREQ   = 8'h3C; // interrupt request bits
	localparam logic [7:0] ADDR_STATUS   = 8'h3D; // processor_status readback
	localparam logic [7:0] ADDR_REWRITE  = 8'h3E; // bit 0: flash self-rewrite mode
	localparam int unsigned RATIO_LSB    = 6;
	localparam logic [7:0] CLKMODE_RESET = 8'h00;
	localparam logic [7:0] IRQREQ_RESET  = 8'h00;
	localparam logic [7:0] DIR_RESET     = 8'h00;

	// ****************************************************************
	// timing
	// ****************************************************************
	localparam longint unsigned MCLK_HZ            = 25000000;
	localparam longint unsigned REWRITE_PHI_MAX_HZ = 4000000; // 4.0 MHz ceiling
	// least divisor keeping phi at or under the ceiling, rounded up
	localparam logic [3:0] REWRITE_MIN_DIV =
		4'((MCLK_HZ + REWRITE_PHI_MAX_HZ - 1) / REWRITE_PHI_MAX_HZ);

	// ****************************************************************
	// operations
	// ****************************************************************
	typedef enum logic [3:0] {
		OP_ADD     = 4'b0000, // add with carry
		OP_SUB     = 4'b0001, // subtract_with_borrow_instr
		OP_SETC    = 4'b0010, // set_carry_instr
		OP_CLRC    = 4'b0011, // clear_carry_instr
		OP_CLRD    = 4'b0100, // clear_decimal_instr
		OP_SETD    = 4'b0101,
		OP_SETI    = 4'b0110,
		OP_CLRI    = 4'b0111,
		OP_SETT    = 4'b1000,
		OP_CLRT    = 4'b1001,
		OP_MUL     = 4'b1010, // product_instr
		OP_DIV     = 4'b1011,
		OP_BBSET   = 4'b1100, // bit_set_branch on interrupt request bit
		OP_BBCLR   = 4'b1101, // bit_clear_branch on interrupt request bit
		OP_NOP     = 4'b1110,
		OP_MOVE    = 4'b1111  // transfer operand to destination
	} cfl_op_e;
endpackage : cfl_pkg

// *** rtl/cfl_adder.sv ***
// Purpose: 8-bit add/subtract with optional decimal adjust
// Assumes: operands are packed BCD when dec is high
// Notes:   purely combinational
`timescale 1ns/10ps
`default_nettype none
module cfl_adder (
	input  wire logic [7:0] a,
	input  wire logic [7:0] b,
	input  wire logic       cin,
	input  wire logic       sub,
	input  wire logic       dec,
	output logic      [7:0] sum,
	output logic            cout,
	output logic            ovf
);
	logic [8:0] bin;
	logic [7:0] bop;
	logic [4:0] lo;
	logic [4:0] hi;
	logic       lc;

	// binary path, subtract as add of inverted operand
	always_comb begin
		bop = sub ? ~b : b;
		bin = {1'b0, a} + {1'b0, bop} + {8'h00, cin};
	end

	// decimal path, nibble by nibble; cin is carry (add) or not-borrow (sub)
	always_comb begin
		lc = 1'b0;
		if (!sub) begin
			lo = {1'b0, a[3:0]} + {1'b0, b[3:0]} + {4'h0, cin};
			if (lo > 5'h09) begin
				lo = lo + 5'h06;
				lc = 1'b1;
			end
			hi = {1'b0, a[7:4]} + {1'b0, b[7:4]} + {4'h0, lc};
			if (hi > 5'h09) hi = hi + 5'h06;
		end else begin
			lo = {1'b0, a[3:0]} - {1'b0, b[3:0]} - {4'h0, ~cin};
			if (lo[4]) begin
				lo = lo - 5'h06;
				lc = 1'b1;
			end
			hi = {1'b0, a[7:4]} - {1'b0, b[7:4]} - {4'h0, lc};
			if (hi[4]) hi = hi - 5'h06;
		end
	end

	// select result; decimal carry is carry-out (add) or not-borrow (sub)
	always_comb begin
		if (dec) begin
			sum  = {hi[3:0], lo[3:0]};
			cout = sub ? ~hi[4] : hi[4];
		end else begin
			sum  = bin[7:0];
			cout = bin[8];
		end
		ovf = (a[7] == bop[7]) && (bin[7] != a[7]);
	end
endmodule : cfl_adder
`default_nettype wire

// *** rtl/cfl_core.sv ***
// Purpose: processor status flags, arithmetic datapath, phi timing and core-side registers
// Assumes: one operation at a time, issued by op_start while busy is low
// Notes:   registers on a plain port, read data one cycle after the read strobe
//
// What this block does
// - reset sets interrupt disable to 1; other status flags need not be defined
// - written interrupt request bits reach bit-test branches only one instruction later
// - decimal flag 1 makes add and subtract produce decimal-adjusted results
// - in decimal mode only carry is meaningful; N, V, Z are not valid
// - multiply and divide ignore the index-X and decimal flags
// - multiply and divide leave the whole status register unchanged
// - port direction registers are write-only; reads never return the stored value
// - execution time equals cycle count times the phi period; a count of zero runs one phi period
// - in self-rewrite mode phi is held at 4.0 MHz or less by a divisor floor over the ratio field
//
// Added by the designer: the address-and-strobe port and the register offsets.
`timescale 1ns/10ps
`default_nettype none
module cfl_core (
	input  wire logic       mclk,
	input  wire logic       rst,
	input  wire logic [7:0] reg_addr,
	input  wire logic [7:0] reg_wdata,
	input  wire logic       reg_wr,
	input  wire logic       reg_rd,
	output logic      [7:0] reg_rdata,
	input  wire logic       op_start,
	input  wire logic [3:0] op_code,
	input  wire logic [3:0] op_cycles,
	input  wire logic [7:0] acc_in,
	input  wire logic [7:0] oper_in,
	input  wire logic [7:0] x_in,
	input  wire logic [7:0] zp_data_in,
	input  wire logic [7:0] irq_event,
	output logic            busy,
	output logic            op_done,
	output logic      [7:0] result,
	output logic      [7:0] result_hi,
	output logic            acc_we,
	output logic            zp_we,
	output logic      [7:0] zp_addr,
	output logic            branch_taken,
	output logic      [7:0] processor_status,
	output logic            phi_tick,
	output logic      [7:0] port_dir0,
	output logic      [7:0] port_dir1,
	output logic            rewrite_mode
);
	// ****************************************************************
	// helpers
	// ****************************************************************
	// phi divisor for each value of the ratio field
	function automatic logic [3:0] ratio_div(input logic [1:0] code);
		unique case (code)
			2'b00:   ratio_div = 4'h2;
			2'b01:   ratio_div = 4'h4;
			2'b10:   ratio_div = 4'h8;
			default: ratio_div = 4'h1;
		endcase
	endfunction : ratio_div

	// refresh the zero and negative flags from a result byte
	function automatic logic [7:0] set_nz(input logic [7:0] ps, input logic [7:0] val);
		set_nz                  = ps;
		set_nz[cfl_pkg::FLAG_Z] = (val == 8'h00);
		set_nz[cfl_pkg::FLAG_N] = val[7];
	endfunction : set_nz

	// ****************************************************************
	// types and storage
	// ****************************************************************
	typedef enum logic {
		ST_IDLE = 1'b0,
		ST_RUN  = 1'b1
	} cfl_state_e;

	cfl_state_e         state;
	cfl_pkg::cfl_op_e   op_q;
	logic        [7:0]  clk_mode;
	logic        [7:0]  irq_req;
	logic        [7:0]  irq_staged;
	logic        [7:0]  irq_visible;
	logic        [3:0]  phi_div;
	logic        [3:0]  phi_cnt;
	logic        [3:0]  cyc_left;
	logic        [7:0]  a_q;
	logic        [7:0]  b_q;
	logic        [7:0]  x_q;
	logic        [7:0]  zp_q;
	logic               use_zp;
	logic               phi_wrap;
	logic               accept;
	logic               finish;
	logic               is_sub;
	logic        [7:0]  add_a;
	logic        [7:0]  add_sum;
	logic               add_cout;
	logic               add_ovf;
	logic        [15:0] product;
	logic        [7:0]  quot;
	logic        [7:0]  remd;
	logic        [7:0]  next_ps;
	logic        [7:0]  next_result;
	logic        [7:0]  next_result_hi;
	logic               next_acc_we;
	logic               next_zp_we;
	logic               next_branch;

	// ****************************************************************
	// phi generation
	// ****************************************************************
	// divisor from the ratio field, with a floor while rewriting flash
	always_comb begin
		phi_div = ratio_div(clk_mode[cfl_pkg::RATIO_LSB +: 2]);
		if (rewrite_mode && (phi_div < cfl_pkg::REWRITE_MIN_DIV)) begin
			phi_div = cfl_pkg::REWRITE_MIN_DIV;
		end
	end

	// greater-or-equal so a divisor shrinking mid-count still wraps
	assign phi_wrap = (phi_cnt >= (phi_div - 4'h1));

	// phi counter; restarted on accept so an instruction lasts whole phi periods
	always_ff @(posedge mclk or posedge rst) begin
		if (rst) begin
			phi_cnt  <= 4'h0;
			phi_tick <= 1'b0;
		end else if (accept) begin
			phi_cnt  <= 4'h0;
			phi_tick <= 1'b0;
		end else if (phi_wrap) begin
			phi_cnt  <= 4'h0;
			phi_tick <= 1'b1;
		end else begin
			phi_cnt  <= phi_cnt + 4'h1;
			phi_tick <= 1'b0;
		end
	end

	// ****************************************************************
	// instruction sequencing
	// ****************************************************************
	// busy is a handshake output and may stay combinational
	assign busy   = (state == ST_RUN);
	assign accept = (state == ST_IDLE) && op_start;
	// a cycle count of zero is taken as one so the core never stalls
	assign finish = (state == ST_RUN) && phi_wrap && (cyc_left <= 4'h1);

	// run state and remaining phi cycles
	always_ff @(posedge mclk or posedge rst) begin
		if (rst) begin
			state    <= ST_IDLE;
			cyc_left <= 4'h0;
		end else if (accept) begin
			state    <= ST_RUN;
			cyc_left <= op_cycles;
		end else if (finish) begin
			state    <= ST_IDLE;
		end else if ((state == ST_RUN) && phi_wrap) begin
			cyc_left <= cyc_left - 4'h1;
		end
	end

	// operands are held from accept so inputs may move during execution
	always_ff @(posedge mclk or posedge rst) begin
		if (rst) begin
			op_q   <= cfl_pkg::OP_NOP;
			a_q    <= 8'h00;
			b_q    <= 8'h00;
			x_q    <= 8'h00;
			zp_q   <= 8'h00;
			use_zp <= 1'b0;
		end else if (accept) begin
			op_q   <= cfl_pkg::cfl_op_e'(op_code);
			a_q    <= acc_in;
			b_q    <= oper_in;
			x_q    <= x_in;
			zp_q   <= zp_data_in;
			use_zp <= processor_status[cfl_pkg::FLAG_T];
		end
	end

	// ****************************************************************
	// datapath
	// ****************************************************************
	assign is_sub = (op_q == cfl_pkg::OP_SUB);
	assign add_a  = use_zp ? zp_q : a_q;

	cfl_adder i_cfl_adder (
		.a    (add_a),
		.b    (b_q),
		.cin  (processor_status[cfl_pkg::FLAG_C]),
		.sub  (is_sub),
		.dec  (processor_status[cfl_pkg::FLAG_D]),
		.sum  (add_sum),
		.cout (add_cout),
		.ovf  (add_ovf)
	);

	// multiply and divide read the accumulator, never the zero-page byte or the mode flags
	always_comb begin
		product = {8'h00, a_q} * {8'h00, b_q};
		if (b_q == 8'h00) begin
			// divide by zero saturates rather than leaving an unknown
			quot = 8'hFF;
			remd = a_q;
		end else begin
			quot = a_q / b_q;
			remd = a_q % b_q;
		end
	end

	// result and flag update decided from the held operation
	always_comb begin
		next_ps        = processor_status;
		next_result    = result;
		next_result_hi = result_hi;
		next_acc_we    = 1'b0;
		next_zp_we     = 1'b0;
		next_branch    = 1'b0;
		unique case (op_q)
			cfl_pkg::OP_ADD, cfl_pkg::OP_SUB: begin
				next_result                   = add_sum;
				next_ps[cfl_pkg::FLAG_C]      = add_cout;
				// in decimal mode N, V and Z stay as they were: they carry no meaning
				if (!processor_status[cfl_pkg::FLAG_D]) begin
					next_ps                  = set_nz(next_ps, add_sum);
					next_ps[cfl_pkg::FLAG_V] = add_ovf;
				end
				next_acc_we = !use_zp;
				next_zp_we  = use_zp;
			end
			cfl_pkg::OP_SETC:  next_ps[cfl_pkg::FLAG_C] = 1'b1;
			cfl_pkg::OP_CLRC:  next_ps[cfl_pkg::FLAG_C] = 1'b0;
			cfl_pkg::OP_CLRD:  next_ps[cfl_pkg::FLAG_D] = 1'b0;
			cfl_pkg::OP_SETD:  next_ps[cfl_pkg::FLAG_D] = 1'b1;
			cfl_pkg::OP_SETI:  next_ps[cfl_pkg::FLAG_I] = 1'b1;
			cfl_pkg::OP_CLRI:  next_ps[cfl_pkg::FLAG_I] = 1'b0;
			cfl_pkg::OP_SETT:  next_ps[cfl_pkg::FLAG_T] = 1'b1;
			cfl_pkg::OP_CLRT:  next_ps[cfl_pkg::FLAG_T] = 1'b0;
			cfl_pkg::OP_MUL: begin
				// status untouched on purpose
				next_result    = product[7:0];
				next_result_hi = product[15:8];
				next_acc_we    = 1'b1;
			end
			cfl_pkg::OP_DIV: begin
				next_result    = quot;
				next_result_hi = remd;
				next_acc_we    = 1'b1;
			end
			cfl_pkg::OP_BBSET: next_branch = irq_visible[b_q[2:0]];
			cfl_pkg::OP_BBCLR: next_branch = !irq_visible[b_q[2:0]];
			cfl_pkg::OP_NOP: begin
				next_ps = processor_status;
			end
			cfl_pkg::OP_MOVE: begin
				next_result = b_q;
				next_ps     = set_nz(next_ps, b_q);
				next_acc_we = !use_zp;
				next_zp_we  = use_zp;
			end
		endcase
	end

	// outputs and status, all taken from flip-flops at the finishing edge
	always_ff @(posedge mclk or posedge rst) begin
		if (rst) begin
			processor_status <= cfl_pkg::PS_RESET;
			result           <= 8'h00;
			result_hi        <= 8'h00;
			branch_taken     <= 1'b0;
			zp_addr          <= 8'h00;
			op_done          <= 1'b0;
			acc_we           <= 1'b0;
			zp_we            <= 1'b0;
		end else begin
			op_done <= finish;
			acc_we  <= finish && next_acc_we;
			zp_we   <= finish && next_zp_we;
			if (finish) begin
				processor_status <= next_ps;
				result           <= next_result;
				result_hi        <= next_result_hi;
				branch_taken     <= next_branch;
				zp_addr          <= x_q;
			end
		end
	end

	// ****************************************************************
	// interrupt request bits
	// ****************************************************************
	// hardware events win over a software write in the same cycle
	always_ff @(posedge mclk or posedge rst) begin
		if (rst) begin
			irq_req <= cfl_pkg::IRQREQ_RESET;
		end else if (reg_wr && (reg_addr == cfl_pkg::ADDR_IRQREQ)) begin
			irq_req <= reg_wdata | irq_event;
		end else begin
			irq_req <= irq_req | irq_event;
		end
	end

	// two-stage copy: a write lands in branch view only after one more instruction
	always_ff @(posedge mclk or posedge rst) begin
		if (rst) begin
			irq_staged  <= cfl_pkg::IRQREQ_RESET;
			irq_visible <= cfl_pkg::IRQREQ_RESET;
		end else begin
			if (accept) begin
				irq_staged <= irq_req;
			end
			if (finish) begin
				irq_visible <= irq_staged;
			end
		end
	end

	// ****************************************************************
	// register port
	// ****************************************************************
	// writable registers
	always_ff @(posedge mclk or posedge rst) begin
		if (rst) begin
			clk_mode     <= cfl_pkg::CLKMODE_RESET;
			port_dir0    <= cfl_pkg::DIR_RESET;
			port_dir1    <= cfl_pkg::DIR_RESET;
			rewrite_mode <= 1'b0;
		end else if (reg_wr) begin
			case (reg_addr)
				cfl_pkg::ADDR_CLKMODE: clk_mode     <= reg_wdata;
				cfl_pkg::ADDR_DIR0:    port_dir0    <= reg_wdata;
				cfl_pkg::ADDR_DIR1:    port_dir1    <= reg_wdata;
				cfl_pkg::ADDR_REWRITE: rewrite_mode <= reg_wdata[0];
				default:               clk_mode     <= clk_mode;
			endcase
		end
	end

	// read data stand for the one cycle after the strobe, zero otherwise
	always_ff @(posedge mclk or posedge rst) begin
		if (rst) begin
			reg_rdata <= 8'h00;
		end else if (reg_rd) begin
			case (reg_addr)
				cfl_pkg::ADDR_CLKMODE: reg_rdata <= clk_mode;
				cfl_pkg::ADDR_IRQREQ:  reg_rdata <= irq_req;
				cfl_pkg::ADDR_STATUS:  reg_rdata <= processor_status;
				cfl_pkg::ADDR_REWRITE: reg_rdata <= {7'h00, rewrite_mode};
				// direction registers fall here: write-only, they read as zero
				default:               reg_rdata <= 8'h00;
			endcase
		end else begin
			reg_rdata <= 8'h00;
		end
	end
endmodule : cfl_core
`default_nettype wire

// *** tb/cfl_core_sva.sv ***
// Purpose: port assertions for the status flag and datapath block
// Assumes: an operation is judged at its op_done pulse
// Notes:   bound from the bench; phi floor of 7 mclk in rewrite mode
`timescale 1ns/10ps
`default_nettype none
module cfl_core_chk (
	input wire logic       mclk,
	input wire logic       rst,
	input wire logic       reg_wr,
	input wire logic       op_start,
	input wire logic       op_done,
	input wire logic       acc_we,
	input wire logic       zp_we,
	input wire logic       phi_tick,
	input wire logic       rewrite_mode,
	input wire logic [3:0] op_code,
	input wire logic [7:0] reg_addr,
	input wire logic [7:0] reg_wdata,
	input wire logic [7:0] acc_in,
	input wire logic [7:0] oper_in,
	input wire logic [7:0] x_in,
	input wire logic [7:0] result,
	input wire logic [7:0] result_hi,
	input wire logic [7:0] zp_addr,
	input wire logic [7:0] processor_status,
	input wire logic [7:0] port_dir0,
	input wire logic [7:0] port_dir1
);
	logic [3:0] op_q;
	logic [7:0] ps_q, a_q, b_q, x_q;
	// launch-time copies, since operands may move before op_done
	always_ff @(posedge mclk or posedge rst) begin
		if (rst) begin
			{op_q, ps_q, a_q, b_q, x_q} <= '0;
		end else if (op_start) begin
			{op_q, ps_q, a_q, b_q, x_q} <= {op_code, processor_status, acc_in, oper_in, x_in};
		end
	end
	default clocking @(posedge mclk); endclocking
	default disable iff (rst);
	sequence s_mul_end;
		op_done && op_q == cfl_pkg::OP_MUL;
	endsequence
	sequence s_move_end;
		op_done && op_q == cfl_pkg::OP_MOVE;
	endsequence
	AST_RST_I: assert property ($fell(rst) |-> processor_status[cfl_pkg::FLAG_I])
		else $error("interrupt disable clear after reset");
	AST_MUL_PS: assert property (s_mul_end |-> processor_status == ps_q)
		else $error("multiply changed status");
	AST_MUL_RES: assert property (s_mul_end |-> {result_hi, result} == a_q * b_q)
		else $error("multiply not binary");
	AST_DIR0: assert property (reg_wr && reg_addr == cfl_pkg::ADDR_DIR0 |=> port_dir0 == $past(reg_wdata))
		else $error("direction 0 not stored");
	AST_DIR1: assert property (reg_wr && reg_addr == cfl_pkg::ADDR_DIR1 |=> port_dir1 == $past(reg_wdata))
		else $error("direction 1 not stored");
	AST_PHI_SLOW: assert property (phi_tick && rewrite_mode |=> !phi_tick [*6])
		else $error("phi too fast in rewrite mode");
	AST_MOVE_ZP: assert property (s_move_end and ps_q[cfl_pkg::FLAG_T] |-> zp_we && !acc_we && zp_addr == x_q)
		else $error("move missed zero page");
	AST_MOVE_ACC: assert property (s_move_end and !ps_q[cfl_pkg::FLAG_T] |-> acc_we && !zp_we)
		else $error("move missed accumulator");
endmodule : cfl_core_chk
`default_nettype wire

// *** tb/cfl_core_tb.sv ***
// Purpose: self-checking bench for the status flag and datapath block
// Assumes: one operation at a time, each ending in op_done
// Notes:   decimal and product expectations are computed here
`timescale 1ns/10ps
`default_nettype none
module cfl_core_tb;
	logic       mclk = 0, rst = 1, reg_wr = 0, reg_rd = 0, op_start = 0;
	logic [3:0] op_code = 4'hE, op_cycles = 4'h2;
	logic [7:0] reg_addr = '0, reg_wdata = '0, acc_in = '0, oper_in = '0, x_in = '0, zp_data_in = '0, irq_event = '0;
	logic [7:0] reg_rdata, result, result_hi, zp_addr, processor_status, port_dir0, port_dir1, a, b, d, ps;
	logic       busy, op_done, acc_we, zp_we, branch_taken, phi_tick, rewrite_mode;
	logic [3:0] cyc_sel = 4'h2;
	int         lat = 0;
	logic [8:0] r;
	int         fails = 0, checks_done = 0, cyc = 0;
	cfl_core i_cfl_core (.*);
	always #20 mclk = ~mclk;
	// hang guard, far above the cycles the sequence needs
	always @(posedge mclk) if (++cyc == 20000) begin fails++; wrap_up(); end
	task automatic check(input logic [15:0] got, exp);
		checks_done++;
		if (got !== exp) begin fails++; $display("[ERR] %0t got %h exp %h", $time, got, exp); end
	endtask : check
	task automatic wr(input logic [7:0] ad, dt);
		@(posedge mclk);
		{reg_addr, reg_wdata, reg_wr} <= {ad, dt, 1'b1};
		@(posedge mclk);
		reg_wr <= 1'b0;
		#1;
	endtask : wr
	task automatic rd(input logic [7:0] ad);
		@(posedge mclk);
		{reg_addr, reg_rd} <= {ad, 1'b1};
		@(posedge mclk);
		reg_rd <= 1'b0;
		#1 d = reg_rdata;
	endtask : rd
	task automatic op(input logic [3:0] c, input logic [7:0] x, y);
		int n = 0;
		@(posedge mclk);
		{op_code, op_cycles, acc_in, oper_in, x_in, zp_data_in, op_start} <= {c, cyc_sel, x, y, 16'($urandom), 1'b1};
		@(posedge mclk);
		op_start <= 1'b0;
		#1;
		while (op_done !== 1'b1 && n < 300) begin @(posedge mclk); #1; n++; end
		if (n == 300) fails++;
		lat = n;
		check(busy, 1'b0);
	endtask : op
	// packed decimal reference; carry means no borrow on subtract
	function automatic logic [8:0] bcd(input logic [7:0] x, y, input logic s);
		int t = s ? 100 + (x[7:4] * 10 + x[3:0]) - (y[7:4] * 10 + y[3:0]) : x[7:4] * 10 + x[3:0] + y[7:4] * 10 + y[3:0];
		return {1'(t >= 100), 4'(t % 100 / 10), 4'(t % 10)};
	endfunction : bcd
	task automatic wrap_up();
		$display("checks %0d fails %0d", checks_done, fails);
		if (fails == 0 && checks_done > 0) $display("ALL CHECKS OK");
		else $display("CHECKS NOT OK");
		$finish;
	endtask : wrap_up
	initial begin
		void'($urandom(98373));
		repeat (6) @(posedge mclk);
		rst <= 1'b0;
		@(posedge mclk);
		#1 check(processor_status[cfl_pkg::FLAG_I], 1'b1);
		op(cfl_pkg::OP_CLRT, 8'h00, 8'h00);
		op(cfl_pkg::OP_SETD, 8'h00, 8'h00);
		for (int i = 0; i < 8; i++) begin
			a = i == 0 ? 8'h99 : {4'($urandom % 10), 4'($urandom % 10)};
			b = i == 0 ? 8'h01 : {4'($urandom % 10), 4'($urandom % 10)};
			op(i[0] ? cfl_pkg::OP_SETC : cfl_pkg::OP_CLRC, 8'h00, 8'h00);
			op(i[0] ? cfl_pkg::OP_SUB : cfl_pkg::OP_ADD, a, b);
			r[7:0] = result;
			op(cfl_pkg::OP_NOP, 8'h00, 8'h00);
			r[8] = processor_status[cfl_pkg::FLAG_C];
			check(r, bcd(a, b, i[0]));
		end
		// products run with both mode flags set, which must not matter
		op(cfl_pkg::OP_SETT, 8'h00, 8'h00);
		for (int i = 0; i < 4; i++) begin
			a = 8'($urandom);
			b = i == 0 ? 8'hFF : 8'($urandom);
			op(cfl_pkg::OP_MOVE, a, b);
			op(cfl_pkg::OP_NOP, 8'h00, 8'h00);
			ps = processor_status;
			op(cfl_pkg::OP_MUL, a, b);
			check({result_hi, result}, a * b);
			check(processor_status, ps);
		end
		op(cfl_pkg::OP_CLRT, 8'h00, 8'h00);
		op(cfl_pkg::OP_MOVE, a, b);
		// a fresh request bit is hidden from the first branch and seen by the next
		wr(cfl_pkg::ADDR_IRQREQ, 8'h01);
		op(cfl_pkg::OP_BBSET, 8'h00, 8'h00);
		check(branch_taken, 1'b0);
		op(cfl_pkg::OP_BBSET, 8'h00, 8'h00);
		check(branch_taken, 1'b1);
		op(cfl_pkg::OP_BBCLR, 8'h00, 8'h00);
		check(branch_taken, 1'b0);
		for (int i = 0; i < 2; i++) begin
			b = 8'h01 | (8'($urandom) & 8'h7E);
			wr(i ? cfl_pkg::ADDR_DIR1 : cfl_pkg::ADDR_DIR0, b);
			check(i ? port_dir1 : port_dir0, b);
			rd(i ? cfl_pkg::ADDR_DIR1 : cfl_pkg::ADDR_DIR0);
			check(d === b, 1'b0);
		end
		rd(8'hF0);
		wr(cfl_pkg::ADDR_CLKMODE, 8'hC0);
		wr(cfl_pkg::ADDR_REWRITE, 8'h01);
		check(rewrite_mode, 1'b1);
		// no interrupts and no flash reads while rewriting
		for (int i = 0; i < 3; i++) begin
			cyc_sel = 4'(1 + $urandom % 4);
			op(cfl_pkg::OP_NOP, 8'h00, 8'h00);
			check(16'(lat), {12'h000, cyc_sel} * cfl_pkg::REWRITE_MIN_DIV);
		end
		wrap_up();
	end
endmodule : cfl_core_tb
bind cfl_core cfl_core_chk i_cfl_core_chk (.*);
`default_nettype wire
